/* rtl/card_slot_controller.sv */
`timescale 1ns/1ps

module card_slot_controller
  import card_slot_pkg::*;
(
  input  wire logic                       ref_clk_in,
  input  wire logic                       resetn_in,
  input  wire logic [HOST_ADDR_WIDTH-1:0] host_addr_in,
  input  wire logic [HOST_DATA_WIDTH-1:0] host_data_in,
  input  wire logic                       host_chip_select_zero_n_in,
  input  wire logic                       host_rd_n_in,
  input  wire logic                       host_bhw_n_in,
  input  wire logic                       host_blw_n_in,
  output logic      [HOST_DATA_WIDTH-1:0] host_data_out,
  output logic                            host_data_oe_n_out,
  output logic                            card_irq_out,
  input  wire logic                       card_detect_a_n_in,
  input  wire logic                       card_detect_b_n_in,
  output logic                            card_ce1_n_out,
  output logic                            card_ce2_n_out,
  output logic                            card_reg_n_out,
  output logic      [CARD_ADDR_WIDTH-1:0] card_addr_out,
  output logic                            card_output_enable_n_out,
  output logic                            card_we_n_out,
  output logic                            card_iord_n_out,
  output logic                            card_iowr_n_out,
  output logic                            card_reset_pin_out,
  output logic                            card_buffer_oe_n_out
);

  card_detect_if det ();

  card_detect_sync u_detect (
    .ref_clk_in         (ref_clk_in),
    .resetn_in          (resetn_in),
    .card_detect_a_n_in (card_detect_a_n_in),
    .card_detect_b_n_in (card_detect_b_n_in),
    .det                (det.source)
  );

  // Host access decode
  wire logic       host_read;
  wire logic       host_write;
  wire logic       reg_area;
  wire logic       card_area;
  wire logic       reg_read;
  wire logic       reg_write;
  wire logic [23:0] reg_addr;
  wire logic       sel_reset_ctl;
  wire logic       sel_status;
  wire logic       sel_irq_en;
  wire logic       sel_buffer_ctl;

  assign host_read  = ~host_chip_select_zero_n_in & ~host_rd_n_in;
  assign host_write = ~host_chip_select_zero_n_in & (~host_bhw_n_in | ~host_blw_n_in);
  assign reg_area   = host_addr_in[HOST_ADDR_WIDTH-1:REG_AREA_LSB] == REG_AREA_TAG;
  assign card_area  = host_addr_in[HOST_ADDR_WIDTH-1:CARD_AREA_LSB] == CARD_AREA_TAG;
  assign reg_read   = host_read & reg_area;
  assign reg_write  = host_write & reg_area;
  assign reg_addr   = {host_addr_in[HOST_ADDR_WIDTH-1:1], 1'b0};

  // Anything else in the register area is reserved and decodes to nothing
  assign sel_reset_ctl  = reg_addr == CARD_RESET_CONTROL_ADDR;
  assign sel_status     = reg_addr == CARD_DETECT_STATUS_ADDR;
  assign sel_irq_en     = reg_addr == CARD_INTERRUPT_ENABLE_ADDR;
  assign sel_buffer_ctl = reg_addr == CARD_BUFFER_CONTROL_ADDR;

  // One write per host strobe: act on the leading edge only
  logic write_seen_q;
  logic read_seen_q;
  wire logic write_take;
  wire logic read_take;
  wire logic hi_lane;
  wire logic lo_lane;

  assign write_take = reg_write & ~write_seen_q;
  assign read_take  = reg_read & ~read_seen_q;
  assign hi_lane    = ~host_bhw_n_in;
  assign lo_lane    = ~host_blw_n_in;

  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      write_seen_q <= 1'b0;
      read_seen_q  <= 1'b0;
    end
    else
    begin
      write_seen_q <= reg_write;
      read_seen_q  <= reg_read;
    end
  end

  // Control registers
  logic output_enable_override_q;
  logic card_reset_bit_q;
  logic insert_remove_irq_enable_q;
  logic buffer_enable_bit_q;
  logic buffer_enable_bit_d;
  logic irq_pending_q;
  logic irq_pending_d;

  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      output_enable_override_q <= CARD_RESET_CONTROL_RST[OUTPUT_ENABLE_OVERRIDE_POS];
      card_reset_bit_q         <= CARD_RESET_CONTROL_RST[CARD_RESET_BIT_POS];
    end
    else if (write_take && sel_reset_ctl)
    begin
      if (hi_lane)
        output_enable_override_q <= host_data_in[OUTPUT_ENABLE_OVERRIDE_POS];
      if (lo_lane)
        card_reset_bit_q <= host_data_in[CARD_RESET_BIT_POS];
    end
  end

  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      insert_remove_irq_enable_q <=
        CARD_INTERRUPT_ENABLE_RST[INSERT_REMOVE_IRQ_ENABLE_POS];
    else if (write_take && sel_irq_en && lo_lane)
      insert_remove_irq_enable_q <= host_data_in[INSERT_REMOVE_IRQ_ENABLE_POS];
  end

  // Buffer enable: removal forces disable; enable only with a card seated
  always_comb
  begin
    buffer_enable_bit_d = buffer_enable_bit_q;
    if (write_take && sel_buffer_ctl && lo_lane)
    begin
      if (host_data_in[BUFFER_ENABLE_BIT_POS])
        buffer_enable_bit_d = 1'b1;
      else if (det.present)
        buffer_enable_bit_d = 1'b0;
    end
    if (det.removed || !det.present)
      buffer_enable_bit_d = 1'b1;
  end

  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      buffer_enable_bit_q <= CARD_BUFFER_CONTROL_RST[BUFFER_ENABLE_BIT_POS];
    else
      buffer_enable_bit_q <= buffer_enable_bit_d;
  end

  // Interrupt request: held until the status register is read or the enable is cleared; a new event wins
  always_comb
  begin
    irq_pending_d = irq_pending_q;
    if (read_take && sel_status)
      irq_pending_d = 1'b0;
    if (!insert_remove_irq_enable_q)
      irq_pending_d = 1'b0;
    if (insert_remove_irq_enable_q && (det.inserted || det.removed))
      irq_pending_d = 1'b1;
  end

  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      irq_pending_q <= 1'b0;
    else
      irq_pending_q <= irq_pending_d;
  end

  // Read data: unassigned bits and reserved addresses read zero
  logic [HOST_DATA_WIDTH-1:0] read_word;

  always_comb
  begin
    read_word = '0;
    if (sel_reset_ctl)
    begin
      read_word[OUTPUT_ENABLE_OVERRIDE_POS] = output_enable_override_q;
      read_word[CARD_RESET_BIT_POS]         = card_reset_bit_q;
    end
    if (sel_status)
      read_word[CARD_PRESENT_POS] = det.present;
    if (sel_irq_en)
      read_word[INSERT_REMOVE_IRQ_ENABLE_POS] = insert_remove_irq_enable_q;
    if (sel_buffer_ctl)
      read_word[BUFFER_ENABLE_BIT_POS] = buffer_enable_bit_q;
  end

  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      host_data_out      <= '0;
      host_data_oe_n_out <= 1'b1;
    end
    else
    begin
      host_data_out      <= reg_read ? read_word : '0;
      host_data_oe_n_out <= ~reg_read;
    end
  end

  // Pin outputs registered: reset pin from its control flop, irq and buffer enable from next-state values
  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      card_irq_out         <= 1'b0;
      card_reset_pin_out   <= CARD_RESET_CONTROL_RST[CARD_RESET_BIT_POS];
      card_buffer_oe_n_out <= CARD_BUFFER_CONTROL_RST[BUFFER_ENABLE_BIT_POS];
    end
    else
    begin
      card_irq_out         <= irq_pending_d;
      card_reset_pin_out   <= card_reset_bit_q;
      card_buffer_oe_n_out <= buffer_enable_bit_d;
    end
  end

  // Card strobes: pure decode so card timing is the host's own cycle, but output enable is held low while output_enable_override_q is clear
  wire logic card_sel;
  wire logic mem_sel;
  wire logic io_sel;

  assign card_sel = ~host_chip_select_zero_n_in & card_area;
  assign mem_sel  = card_sel & ~host_addr_in[MEM_SEL_N_POS];
  assign io_sel   = card_sel & ~host_addr_in[IO_SEL_N_POS];

  always_comb
  begin
    card_ce1_n_out  = card_sel ? host_addr_in[CE1_SEL_POS] : 1'b1;
    card_ce2_n_out  = card_sel ? host_addr_in[CE2_SEL_POS] : 1'b1;
    card_reg_n_out  = card_sel ? host_addr_in[ATTR_SEL_N_POS] : 1'b1;
    card_addr_out   = {host_addr_in[CARD_A0_POS-1:1], host_addr_in[CARD_A0_POS]};
    card_we_n_out   = ~(mem_sel & host_write);
    card_iord_n_out = ~(io_sel & host_read);
    card_iowr_n_out = ~(io_sel & host_write);
    if (output_enable_override_q)
      card_output_enable_n_out = ~(mem_sel & host_read);
    else
      card_output_enable_n_out = 1'b0;
  end

endmodule : card_slot_controller

/* rtl/card_slot_pkg.sv */
package card_slot_pkg;

  localparam int unsigned HOST_ADDR_WIDTH = 24;
  localparam int unsigned HOST_DATA_WIDTH = 16;

  // Register area within the chip-select 0 space
  localparam logic [23:0] REG_AREA_BASE  = 24'h20_0000;
  localparam logic [9:0]  REG_AREA_TAG   = 10'h080;
  localparam int unsigned REG_AREA_LSB   = 14;

  // Register byte addresses
  localparam logic [23:0] CARD_RESET_CONTROL_ADDR    = 24'h20_0000;
  localparam logic [23:0] CARD_DETECT_STATUS_ADDR    = 24'h20_0002;
  localparam logic [23:0] CARD_INTERRUPT_ENABLE_ADDR = 24'h20_0004;
  localparam logic [23:0] CARD_BUFFER_CONTROL_ADDR   = 24'h20_0006;

  // Reset values
  localparam logic [15:0] CARD_RESET_CONTROL_RST    = 16'h0100;
  localparam logic [15:0] CARD_INTERRUPT_ENABLE_RST = 16'h0000;
  localparam logic [15:0] CARD_BUFFER_CONTROL_RST   = 16'h0001;

  // Field positions (bit 0 is the least significant data line)
  localparam int unsigned OUTPUT_ENABLE_OVERRIDE_POS   = 8;
  localparam int unsigned CARD_RESET_BIT_POS           = 0;
  localparam int unsigned CARD_PRESENT_POS             = 0;
  localparam int unsigned INSERT_REMOVE_IRQ_ENABLE_POS = 0;
  localparam int unsigned BUFFER_ENABLE_BIT_POS        = 0;

  // Card area decode: host address bits steering card signals
  localparam logic [4:0]  CARD_AREA_TAG   = 5'h05;
  localparam int unsigned CARD_AREA_LSB   = 19;
  localparam int unsigned CE2_SEL_POS     = 16;
  localparam int unsigned CE1_SEL_POS     = 15;
  localparam int unsigned IO_SEL_N_POS    = 14;
  localparam int unsigned MEM_SEL_N_POS   = 13;
  localparam int unsigned ATTR_SEL_N_POS  = 12;
  localparam int unsigned CARD_A0_POS     = 11;
  localparam int unsigned CARD_ADDR_WIDTH = 11;

  // Detect synchroniser depth and warm-up
  localparam int unsigned SYNC_STAGES = 2;

endpackage : card_slot_pkg

/* rtl/card_detect_if.sv */
`timescale 1ns/1ps

interface card_detect_if;
  logic present;
  logic inserted;
  logic removed;

  modport source (
    output present,
    output inserted,
    output removed
  );

  modport sink (
    input present,
    input inserted,
    input removed
  );
endinterface : card_detect_if

/* rtl/card_detect_sync.sv */
`timescale 1ns/1ps

module card_detect_sync
  import card_slot_pkg::*;
(
  input  wire logic    ref_clk_in,
  input  wire logic    resetn_in,
  input  wire logic    card_detect_a_n_in,
  input  wire logic    card_detect_b_n_in,
  card_detect_if.source det
);

  logic [1:0] meta_q;
  logic [1:0] sync_q;
  logic [1:0] armed_q;
  logic       present_q;
  logic       inserted_q;
  logic       removed_q;
  logic       live_q;
  wire  logic present_d;
  wire  logic armed;

  // Card counts as seated only when both detect contacts are low
  assign present_d = ~sync_q[0] & ~sync_q[1];
  assign armed     = armed_q[1];

  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      meta_q  <= 2'h3;
      sync_q  <= 2'h3;
      armed_q <= 2'h0;
    end
    else
    begin
      meta_q  <= {card_detect_b_n_in, card_detect_a_n_in};
      sync_q  <= meta_q;
      armed_q <= {armed_q[0], 1'b1};
    end
  end

  // Status follows the slot once the synchroniser holds real samples
  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      present_q  <= 1'b0;
      inserted_q <= 1'b0;
      removed_q  <= 1'b0;
      live_q     <= 1'b0;
    end
    else
    begin
      // Edges count only after the first real sample, so a card seated at reset is no event
      live_q     <= armed;
      present_q  <= armed ? present_d : 1'b0;
      inserted_q <= live_q & present_d & ~present_q;
      removed_q  <= live_q & ~present_d & present_q;
    end
  end

  assign det.present  = present_q;
  assign det.inserted = inserted_q;
  assign det.removed  = removed_q;

endmodule : card_detect_sync

/* sim/card_slot_model.sv */
`timescale 1ns/1ps

module card_slot_model
(
  input  wire logic [1:0] contacts_in,
  output logic            card_detect_a_n_out,
  output logic            card_detect_b_n_out
);
  // An open contact leaves its pulled-up detect line high
  assign card_detect_a_n_out = contacts_in[0] ? 1'b0 : 1'b1;
  assign card_detect_b_n_out = contacts_in[1] ? 1'b0 : 1'b1;
endmodule : card_slot_model

/* sim/card_slot_controller_asserts.sv */
`timescale 1ns/1ps

module card_slot_controller_asserts
  import card_slot_pkg::*;
(
  input wire logic                       ref_clk_in,
  input wire logic                       resetn_in,
  input wire logic [HOST_ADDR_WIDTH-1:0] host_addr_in,
  input wire logic                       host_chip_select_zero_n_in,
  input wire logic                       host_rd_n_in,
  input wire logic                       host_blw_n_in,
  input wire logic [HOST_DATA_WIDTH-1:0] host_data_out,
  input wire logic                       host_data_oe_n_out,
  input wire logic                       card_irq_out,
  input wire logic                       card_detect_a_n_in,
  input wire logic                       card_detect_b_n_in,
  input wire logic                       card_ce1_n_out,
  input wire logic                       card_ce2_n_out,
  input wire logic                       card_reg_n_out,
  input wire logic [CARD_ADDR_WIDTH-1:0] card_addr_out,
  input wire logic                       card_reset_pin_out,
  input wire logic                       card_buffer_oe_n_out
);
  logic       host_sel;
  logic       card_sel;
  logic       rd_reg;
  logic       wr_rst;
  logic [1:0] pins;
  logic [1:0] pins_q;
  logic [3:0] since_q;
  logic [3:0] since_d;

  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!resetn_in);

  assign host_sel = !host_chip_select_zero_n_in;
  assign card_sel = host_sel && !host_rd_n_in && host_addr_in[23:19] == CARD_AREA_TAG;
  assign rd_reg   = host_sel && !host_rd_n_in && host_addr_in[23:14] == REG_AREA_TAG;
  assign wr_rst   = host_sel && !host_blw_n_in && host_addr_in == CARD_RESET_CONTROL_ADDR;
  assign pins     = {card_detect_a_n_in, card_detect_b_n_in};
  // Cycles since the last detect pin change, saturating
  assign since_d  = (pins != pins_q) ? 4'h0 : (since_q == 4'hF) ? since_q : since_q + 4'h1;

  always_ff @(posedge ref_clk_in or negedge resetn_in)
    if (!resetn_in)
    begin
      pins_q  <= 2'h3;
      since_q <= 4'hF;
    end
    else
    begin
      pins_q  <= pins;
      since_q <= since_d;
    end

  ce_decode_a: assert property (card_sel |-> card_ce1_n_out == host_addr_in[15]
    && card_ce2_n_out == host_addr_in[16]) else $error("card enables miss decode");
  reg_addr_a: assert property (card_sel |-> card_reg_n_out == host_addr_in[12]
    && card_addr_out == {host_addr_in[10:1], host_addr_in[11]})
    else $error("card select or address miss decode");
  read_enable_a: assert property (!host_data_oe_n_out |-> $past(rd_reg))
    else $error("read data driven without a register read");
  idle_zero_a: assert property (host_data_oe_n_out |-> host_data_out == 16'h0000)
    else $error("read data not zero while idle");
  reserved_zero_a: assert property ($past(rd_reg && host_addr_in[13:3] != 11'h000)
    |-> host_data_out == 16'h0000) else $error("reserved read not zero");
  status_bits_a: assert property ($past(rd_reg && host_addr_in[13:0] == 14'h0002)
    |-> host_data_out[15:1] == 15'h0000) else $error("status unassigned bits not zero");
  reset_pin_a: assert property ($changed(card_reset_pin_out)
    |-> $past(wr_rst, 1) || $past(wr_rst, 2)) else $error("reset pin moved without a write");
  buffer_off_a: assert property ((card_detect_a_n_in || card_detect_b_n_in)[*6]
    |-> card_buffer_oe_n_out) else $error("buffers on with no card");
  irq_cause_a: assert property ($rose(card_irq_out) |-> since_q <= 4'h5)
    else $error("interrupt without a detect change");
endmodule : card_slot_controller_asserts

bind card_slot_controller card_slot_controller_asserts i_card_slot_controller_asserts (
  .ref_clk_in                 (ref_clk_in),
  .resetn_in                  (resetn_in),
  .host_addr_in               (host_addr_in),
  .host_chip_select_zero_n_in (host_chip_select_zero_n_in),
  .host_rd_n_in               (host_rd_n_in),
  .host_blw_n_in              (host_blw_n_in),
  .host_data_out              (host_data_out),
  .host_data_oe_n_out         (host_data_oe_n_out),
  .card_irq_out               (card_irq_out),
  .card_detect_a_n_in         (card_detect_a_n_in),
  .card_detect_b_n_in         (card_detect_b_n_in),
  .card_ce1_n_out             (card_ce1_n_out),
  .card_ce2_n_out             (card_ce2_n_out),
  .card_reg_n_out             (card_reg_n_out),
  .card_addr_out              (card_addr_out),
  .card_reset_pin_out         (card_reset_pin_out),
  .card_buffer_oe_n_out       (card_buffer_oe_n_out)
);

/* sim/test_card_slot_controller.sv */
`timescale 1ns/1ps

module test_card_slot_controller
  import card_slot_pkg::*;
;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic [23:0] addr = 24'h00_0000;
  logic [15:0] wdata = 16'h0000;
  logic        cs0_n = 1'b1;
  logic        rd_n = 1'b1;
  logic        we_n = 1'b1;
  logic [1:0]  contacts = 2'h0;
  logic        det_a_n;
  logic        det_b_n;
  logic [15:0] data_out;
  logic        irq;
  logic        ce1_n;
  logic        ce2_n;
  logic        reg_n;
  logic        oe_n;
  logic        rst_pin;
  logic        buf_oe_n;
  logic        data_oe_n;
  logic [10:0] card_addr;
  logic        cwe_n;
  logic        iord_n;
  logic        iowr_n;
  int          bad_count = 0;
  int          n_compared = 0;

  always #2.5 clk = ~clk;

  card_slot_model i_card_slot_model (.contacts_in(contacts), .card_detect_a_n_out(det_a_n),
    .card_detect_b_n_out(det_b_n));

  card_slot_controller i_card_slot_controller (.ref_clk_in(clk), .resetn_in(resetn),
    .host_addr_in(addr), .host_data_in(wdata), .host_chip_select_zero_n_in(cs0_n),
    .host_rd_n_in(rd_n), .host_bhw_n_in(we_n), .host_blw_n_in(we_n),
    .host_data_out(data_out), .host_data_oe_n_out(data_oe_n), .card_irq_out(irq),
    .card_detect_a_n_in(det_a_n), .card_detect_b_n_in(det_b_n), .card_ce1_n_out(ce1_n),
    .card_ce2_n_out(ce2_n), .card_reg_n_out(reg_n), .card_addr_out(card_addr),
    .card_output_enable_n_out(oe_n), .card_we_n_out(cwe_n), .card_iord_n_out(iord_n),
    .card_iowr_n_out(iowr_n), .card_reset_pin_out(rst_pin), .card_buffer_oe_n_out(buf_oe_n));

  task automatic check(input string name, input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
      bad_count++;
    end
  endtask : check

  task automatic wr(input logic [23:0] a, input logic [15:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    cs0_n = 1'b0;
    we_n = 1'b0;
    @(negedge clk);
    cs0_n = 1'b1;
    we_n = 1'b1;
    repeat (2) @(negedge clk);
  endtask : wr

  task automatic rd(input logic [23:0] a, input logic [15:0] e, input string n);
    @(negedge clk);
    addr = a;
    cs0_n = 1'b0;
    rd_n = 1'b0;
    @(negedge clk);
    check(n, data_out, e);
    check("read enable", {15'h0000, data_oe_n}, 16'h0000);
    rd_n = 1'b1;
    cs0_n = 1'b1;
    @(negedge clk);
    check("read enable idle", {15'h0000, data_oe_n}, 16'h0001);
  endtask : rd

  // Card read or write, or idle bus; strobes probed in the same cycle
  task automatic probe(input logic [23:0] a, input logic active, input logic w,
    input logic [15:0] e);
    @(negedge clk);
    addr = a;
    cs0_n = ~active;
    rd_n = ~(active & ~w);
    we_n = ~(active & w);
    #1 check("card strobes", {9'h000, cwe_n, iord_n, iowr_n, ce2_n, ce1_n, reg_n, oe_n}, e);
    check("card address", {5'h00, card_addr}, {5'h00, a[10:1], a[11]});
    @(negedge clk);
    cs0_n = 1'b1;
    rd_n = 1'b1;
    we_n = 1'b1;
  endtask : probe

  task automatic seat(input logic [1:0] c);
    contacts = c;
    repeat (6) @(negedge clk);
  endtask : seat

  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : complete_run

  initial
  begin
    repeat (5000) @(posedge clk);
    bad_count++;
    complete_run;
  end

  initial
  begin
    repeat (20) @(negedge clk);
    resetn = 1'b1;
    rd(CARD_RESET_CONTROL_ADDR, CARD_RESET_CONTROL_RST, "reset control");
    rd(CARD_DETECT_STATUS_ADDR, 16'h0000, "status empty");
    rd(CARD_INTERRUPT_ENABLE_ADDR, CARD_INTERRUPT_ENABLE_RST, "irq enable");
    rd(CARD_BUFFER_CONTROL_ADDR, CARD_BUFFER_CONTROL_RST, "buffer control");
    check("pins after reset", {13'h0000, rst_pin, buf_oe_n, irq}, 16'h0002);
    rd(24'h20_0008, 16'h0000, "reserved");
    wr(CARD_BUFFER_CONTROL_ADDR, 16'h0000);
    rd(CARD_BUFFER_CONTROL_ADDR, 16'h0001, "buffer no card");
    wr(CARD_RESET_CONTROL_ADDR, 16'hFFFF);
    rd(CARD_RESET_CONTROL_ADDR, 16'h0101, "reset control");
    check("reset pin", {15'h0000, rst_pin}, 16'h0001);
    probe(24'h29_4200, 1'b1, 1'b0, 16'h0078);
    probe(24'h29_4200, 1'b0, 1'b0, 16'h007F);
    wr(CARD_RESET_CONTROL_ADDR, 16'h0001);
    probe(24'h29_4200, 1'b0, 1'b0, 16'h007E);
    wr(CARD_RESET_CONTROL_ADDR, 16'h0100);
    check("reset pin", {15'h0000, rst_pin}, 16'h0000);
    probe(24'h28_5000, 1'b1, 1'b1, 16'h0033);
    probe(24'h29_2000, 1'b1, 1'b1, 16'h0069);
    probe(24'h29_2000, 1'b1, 1'b0, 16'h0059);
    wr(CARD_INTERRUPT_ENABLE_ADDR, 16'h0001);
    seat(2'b01);
    rd(CARD_DETECT_STATUS_ADDR, 16'h0000, "half seated");
    check("irq half seated", {15'h0000, irq}, 16'h0000);
    seat(2'b11);
    check("irq insert", {15'h0000, irq}, 16'h0001);
    wr(CARD_DETECT_STATUS_ADDR, 16'h0000);
    rd(CARD_DETECT_STATUS_ADDR, 16'h0001, "status card");
    check("irq cleared", {15'h0000, irq}, 16'h0000);
    wr(CARD_BUFFER_CONTROL_ADDR, 16'h0000);
    rd(CARD_BUFFER_CONTROL_ADDR, 16'h0000, "buffer on");
    check("buffer pin on", {15'h0000, buf_oe_n}, 16'h0000);
    probe(24'h29_4200, 1'b1, 1'b0, 16'h0078);
    seat(2'b00);
    check("buffer pin removed", {15'h0000, buf_oe_n, irq}, 16'h0003);
    rd(CARD_BUFFER_CONTROL_ADDR, 16'h0001, "buffer removed");
    rd(CARD_DETECT_STATUS_ADDR, 16'h0000, "status removed");
    wr(CARD_INTERRUPT_ENABLE_ADDR, 16'h0000);
    seat(2'b11);
    check("irq masked", {15'h0000, irq}, 16'h0000);
    resetn = 1'b0;
    repeat (2) @(negedge clk);
    resetn = 1'b1;
    wr(CARD_INTERRUPT_ENABLE_ADDR, 16'h0001);
    repeat (6) @(negedge clk);
    check("irq seated at reset", {15'h0000, irq}, 16'h0000);
    rd(CARD_DETECT_STATUS_ADDR, 16'h0001, "status seated at reset");
    complete_run;
  end
endmodule : test_card_slot_controller
